// *** fgs_consts.svh ***
// Constants for the FIB grid scheduler: offsets, field positions, counts
// ============================================================
// Functional notes
// - Grid holds 500 records, one per CIF
// - Record zero sits at CIF low bits zero on activation
// - Grid index wraps cyclically every 500 CIFs
// - Open, ten record messages, then close
// - Clean session end stores grid as valid
// - Grid request answered by session or error
// - Record messages only inside an open session
// - Each record message carries fifty records
// - Record bit one grants upstream, MSB first
// - Outside mode three the record LSB is zero
// - Activate only when both ends hold grid
// - Activate at first low-nine-zero CIF after time
// - Active grid stays until next activation
// - Activation time is valid HH:MM:SS form
// - Error carries four-character cause code
// - Error on grid content aborts open session
`ifndef FGS_CONSTS_SVH
`define FGS_CONSTS_SVH
// ============================================================
// Grid geometry
`define FGS_GRID_LEN   500
`define FGS_LAST_IDX   9'h1F3
`define FGS_LAST_FILL  6'h31
`define FGS_MSG_TOTAL  4'hA
`define FGS_ALLOC_W    200
// ============================================================
// Register byte offsets
`define FGS_OFF_CTRL   12'h000
`define FGS_OFF_STAT   12'h004
`define FGS_OFF_TIME   12'h008
`define FGS_OFF_IDX    12'h00C
`define FGS_OFF_GRID   1'h1
// Control and status bit positions
`define FGS_CTRL_SESS  0
`define FGS_CTRL_ACT   1
`define FGS_CTRL_STAGE 2
`define FGS_CTRL_MODE3 3
`define FGS_STAT_REF   5
`define FGS_STAT_ABT   6
// ============================================================
// Time limits and message characters
`define FGS_TIME_RST   24'h000000
`define FGS_HH_MAX     8'h23
`define FGS_MS_MAX     8'h59
`define FGS_CHR_COLON  8'h3A
`define FGS_CHR_DIGIT  4'h3
`define FGS_CAUSE_GRID 32'h47524944
`define FGS_CAUSE_CNT  32'h4E524543
`endif

// *** fgs_pkg.sv ***
// Types for the FIB grid scheduler
`default_nettype none
`include "fgs_consts.svh"
package fgs_pkg;
  // ============================================================
  // Sequencer states and message kinds
  typedef enum logic [1:0] {S_IDLE, S_FILL, S_SEND} fgs_state_t;
  typedef enum logic [2:0] {K_OPEN, K_REC, K_CLOSE, K_ACT, K_ERR} fgs_kind_t;
  typedef enum logic {IN_REQ, IN_ERR} fgs_in_t;
  // ============================================================
  // Whole block state
  typedef struct packed {
    fgs_state_t                    st;
    fgs_kind_t                     kind;
    logic                          ack;
    logic [31:0]                   rdata;
    logic                          mode3;
    logic                          stage_ok;
    logic                          far_ok;
    logic                          act_ok;
    logic                          pend;
    logic                          armed;
    logic                          bank;
    logic                          refused;
    logic                          aborted;
    logic [8:0]                    idx;
    logic [8:0]                    rd_ptr;
    logic [3:0]                    rec_n;
    logic [5:0]                    fill;
    logic [`FGS_ALLOC_W-1:0]       alloc;
    logic [23:0]                   act_time;
    logic [3:0]                    grant;
  } fgs_regs_t;
endpackage
`default_nettype wire

// *** fgs_scheduler.sv ***
// FIB grid scheduler: grid store, transfer session, timed activation
`timescale 1ns/1ps
`default_nettype none
`include "fgs_consts.svh"
module fgs_scheduler (
  // Clock and reset
  input  wire logic                     I_CLK_SYS,
  input  wire logic                     I_RESET,
  // Avalon-MM slave
  input  wire logic [11:0]              I_AVS_ADDRESS,
  input  wire logic                     I_AVS_READ,
  input  wire logic                     I_AVS_WRITE,
  input  wire logic [31:0]              I_AVS_WRITEDATA,
  input  wire logic [3:0]               I_AVS_BYTEENABLE,
  output logic      [31:0]              O_AVS_READDATA,
  output logic                          O_AVS_WAITREQUEST,
  // Messages from upstream
  input  wire logic                     I_IN_VALID,
  input  wire fgs_pkg::fgs_in_t         I_IN_KIND,
  input  wire logic [31:0]              I_IN_CAUSE,
  // Messages to upstream
  output logic                          O_MSG_VALID,
  input  wire logic                     I_MSG_READY,
  output var fgs_pkg::fgs_kind_t        O_MSG_KIND,
  output logic      [`FGS_ALLOC_W-1:0]  O_MSG_ALLOC,
  output logic      [63:0]              O_MSG_UTC,
  output logic      [31:0]              O_MSG_CAUSE,
  // Frame timing
  input  wire logic                     I_CIF_TICK,
  input  wire logic [12:0]              I_CIF_COUNT,
  input  wire logic [23:0]              I_UTC_BCD,
  // FIB allocation for the current CIF
  output logic      [3:0]               O_FIB_GRANT,
  output logic                          O_GRANT_VALID
);
  import fgs_pkg::*;

  // ============================================================
  // Helpers
  // Accept only real BCD times within a day
  function automatic logic time_ok(input logic [23:0] t);
    time_ok = (t[23:16] <= `FGS_HH_MAX) && (t[19:16] <= 4'h9) &&
              (t[15:8] <= `FGS_MS_MAX) && (t[11:8] <= 4'h9) &&
              (t[7:0] <= `FGS_MS_MAX) && (t[3:0] <= 4'h9);
  endfunction

  // BCD time to the eight-character HH:MM:SS field
  function automatic logic [63:0] to_ascii(input logic [23:0] t);
    to_ascii = {`FGS_CHR_DIGIT, t[23:20], `FGS_CHR_DIGIT, t[19:16], `FGS_CHR_COLON,
                `FGS_CHR_DIGIT, t[15:12], `FGS_CHR_DIGIT, t[11:8], `FGS_CHR_COLON,
                `FGS_CHR_DIGIT, t[7:4], `FGS_CHR_DIGIT, t[3:0]};
  endfunction

  // Fourth FIB only exists in mode three
  function automatic logic [3:0] fib_mask(input logic [3:0] v, input logic m3);
    fib_mask = {v[3:1], v[0] & m3};
  endfunction

  // ============================================================
  // State, memory and decode
  fgs_regs_t   r;
  fgs_regs_t   n;
  logic [3:0]  grid_mem [0:1][0:`FGS_GRID_LEN-1];
  logic        bus_req;
  logic        bus_wr;
  logic        grid_hit;
  logic        grid_wr;
  logic [8:0]  bus_idx;
  logic        start_req;
  logic        act_req;
  logic        in_err;
  logic        in_sess;
  logic        b_new;
  logic [8:0]  i_new;
  logic [3:0]  g_rec;
  logic        ctrl_wr;

  // Bus decode; a write lands on the edge where waitrequest is low
  assign bus_req  = I_AVS_READ | I_AVS_WRITE;
  assign bus_wr   = I_AVS_WRITE & r.ack;
  assign bus_idx  = I_AVS_ADDRESS[10:2];
  assign grid_hit = (I_AVS_ADDRESS[11] == `FGS_OFF_GRID) && (bus_idx <= `FGS_LAST_IDX);
  // Grid edits are locked out while a session streams the stage bank
  assign grid_wr  = bus_wr & grid_hit & I_AVS_BYTEENABLE[0] & (r.st == S_IDLE);
  assign ctrl_wr  = bus_wr & (I_AVS_ADDRESS == `FGS_OFF_CTRL) & I_AVS_BYTEENABLE[0];
  // Only requests and errors can come from upstream
  assign start_req = (ctrl_wr & I_AVS_WRITEDATA[`FGS_CTRL_SESS]) |
                     (I_IN_VALID & (I_IN_KIND == IN_REQ));
  assign act_req   = ctrl_wr & I_AVS_WRITEDATA[`FGS_CTRL_ACT];
  assign in_err    = I_IN_VALID & (I_IN_KIND == IN_ERR);
  assign in_sess   = (r.st == S_FILL) ||
                     ((r.st == S_SEND) && (r.kind inside {K_OPEN, K_REC, K_CLOSE}));

  // Stage bank is the one not in use; active bank stays untouched
  always_ff @(posedge I_CLK_SYS)
  begin
    if (grid_wr)
      grid_mem[~r.bank][bus_idx] <= fib_mask(I_AVS_WRITEDATA[3:0], r.mode3);
  end

  // ============================================================
  // Next state
  always_comb
  begin
    n     = r;
    b_new = r.bank;
    i_new = r.idx;
    g_rec = 4'h0;
    // One wait state on every access
    n.ack = bus_req & ~r.ack;
    if (bus_req & ~r.ack & I_AVS_READ)
    begin
      n.rdata = 32'h0;
      if (grid_hit)
        n.rdata = {28'h0, grid_mem[~r.bank][bus_idx]};
      else if (I_AVS_ADDRESS == `FGS_OFF_CTRL)
        n.rdata = {28'h0, r.mode3, r.stage_ok, 2'h0};
      else if (I_AVS_ADDRESS == `FGS_OFF_STAT)
        n.rdata = {20'h0, r.rec_n, r.bank, r.aborted, r.refused, r.pend,
                   r.act_ok, r.far_ok, r.stage_ok, r.st != S_IDLE};
      else if (I_AVS_ADDRESS == `FGS_OFF_TIME)
        n.rdata = {8'h0, r.act_time};
      else if (I_AVS_ADDRESS == `FGS_OFF_IDX)
        n.rdata = {22'h0, r.bank, r.idx};
    end

    // Software control; sticky flags clear first so a new event wins
    if (ctrl_wr)
    begin
      n.mode3 = I_AVS_WRITEDATA[`FGS_CTRL_MODE3];
      if (I_AVS_WRITEDATA[`FGS_CTRL_STAGE])
        n.stage_ok = 1'b1;
    end
    if (bus_wr & (I_AVS_ADDRESS == `FGS_OFF_STAT) & I_AVS_BYTEENABLE[0])
    begin
      if (I_AVS_WRITEDATA[`FGS_STAT_REF])
        n.refused = 1'b0;
      if (I_AVS_WRITEDATA[`FGS_STAT_ABT])
        n.aborted = 1'b0;
    end
    if (bus_wr & (I_AVS_ADDRESS == `FGS_OFF_TIME) & (I_AVS_BYTEENABLE[2:0] == 3'h7))
    begin
      if (time_ok(I_AVS_WRITEDATA[23:0]) && !r.pend)
        n.act_time = I_AVS_WRITEDATA[23:0];
      else
        n.refused = 1'b1;
    end
    // Far copy no longer matches once the stage bank is edited
    if (grid_wr)
      n.far_ok = 1'b0;

    // Session and message sequencer
    unique case (r.st)
      S_IDLE:
      begin
        if (start_req)
        begin
          n.st     = S_SEND;
          n.kind   = r.stage_ok ? K_OPEN : K_ERR;
          n.rec_n  = 4'h0;
          n.rd_ptr = 9'h0;
          n.fill   = 6'h0;
        end
        else if (act_req)
        begin
          if (r.stage_ok & r.far_ok)
          begin
            n.st   = S_SEND;
            n.kind = K_ACT;
          end
          else
            n.refused = 1'b1;
        end
      end
      S_FILL:
      begin
        // First record read ends up in the top nibble
        n.alloc  = {r.alloc[`FGS_ALLOC_W-5:0], grid_mem[~r.bank][r.rd_ptr]};
        n.rd_ptr = r.rd_ptr + 9'h1;
        n.fill   = r.fill + 6'h1;
        if (r.fill == `FGS_LAST_FILL)
        begin
          n.st   = S_SEND;
          n.kind = K_REC;
          n.fill = 6'h0;
        end
      end
      S_SEND:
      begin
        if (I_MSG_READY)
        begin
          n.st = S_IDLE;
          unique case (r.kind)
            K_OPEN:
              n.st = S_FILL;
            K_REC:
            begin
              n.rec_n = r.rec_n + 4'h1;
              n.st    = S_SEND;
              n.kind  = K_CLOSE;
              if (r.rec_n + 4'h1 != `FGS_MSG_TOTAL)
                n.st = S_FILL;
            end
            K_CLOSE:
              n.far_ok = 1'b1;
            K_ACT:
              n.pend = 1'b1;
            K_ERR:
              n.st = S_IDLE;
          endcase
        end
      end
    endcase
    if ((start_req | act_req) & (r.st != S_IDLE))
      n.refused = 1'b1;

    // Upstream error: grid lost far away, or session aborted
    if (in_err)
    begin
      if (I_IN_CAUSE == `FGS_CAUSE_GRID)
      begin
        n.far_ok = 1'b0;
        n.pend   = 1'b0;
        n.armed  = 1'b0;
        if ((r.st == S_SEND) && (r.kind == K_ACT))
          n.st = S_IDLE;
      end
      else if (in_sess)
      begin
        // Stage bank and active bank are both left as they were
        n.st      = S_IDLE;
        n.aborted = 1'b1;
        // A close accepted in the same cycle does not count
        n.far_ok  = r.far_ok;
      end
    end

    // Time compare is within one day; no wrap past midnight
    // A pending activation dropped this cycle must not arm
    if (r.pend && n.pend && (I_UTC_BCD > r.act_time))
      n.armed = 1'b1;
    if (I_CIF_TICK)
    begin
      if (r.armed && (I_CIF_COUNT[8:0] == 9'h0))
      begin
        b_new      = ~r.bank;
        i_new      = 9'h0;
        n.act_ok   = 1'b1;
        n.pend     = 1'b0;
        n.armed    = 1'b0;
        n.stage_ok = 1'b0;
        n.far_ok   = 1'b0;
      end
      else
        i_new = (r.idx == `FGS_LAST_IDX) ? 9'h0 : r.idx + 9'h1;
      g_rec   = grid_mem[b_new][i_new];
      n.bank  = b_new;
      n.idx   = i_new;
      n.grant = n.act_ok ? fib_mask(g_rec, r.mode3) : 4'h0;
    end
    // Leaving mode three withdraws the fourth FIB at once
    n.grant = fib_mask(n.grant, n.mode3);
  end

  // ============================================================
  // State register
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RESET)
      r <= '0;
    else
      r <= n;
  end

  // ============================================================
  // Outputs
  assign O_AVS_WAITREQUEST = bus_req & ~r.ack;
  assign O_AVS_READDATA    = r.rdata;
  assign O_MSG_VALID       = (r.st == S_SEND);
  assign O_MSG_KIND        = r.kind;
  assign O_MSG_ALLOC       = r.alloc;
  assign O_MSG_UTC         = to_ascii(r.act_time);
  assign O_MSG_CAUSE       = `FGS_CAUSE_GRID;
  assign O_FIB_GRANT       = r.grant;
  assign O_GRANT_VALID     = r.act_ok;

  // ============================================================
  // Checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);

  logic send_acc;
  assign send_acc = O_MSG_VALID & I_MSG_READY;

  rec_in_session_a: assert property (O_MSG_VALID && (O_MSG_KIND == K_REC) |-> r.rec_n < `FGS_MSG_TOTAL)
    else $error("record message outside session");
  ten_then_close_a: assert property (send_acc && (O_MSG_KIND == K_CLOSE) |-> r.rec_n == `FGS_MSG_TOTAL)
    else $error("close without ten records");
  close_stores_a: assert property (send_acc && (O_MSG_KIND == K_CLOSE) && !in_err |=> r.far_ok)
    else $error("grid not stored after close");
  request_answer_a: assert property (I_IN_VALID && (I_IN_KIND == IN_REQ) && (r.st == S_IDLE)
                                     |=> O_MSG_VALID && (O_MSG_KIND inside {K_OPEN, K_ERR}))
    else $error("grid request not answered");
  act_needs_grid_a: assert property (O_MSG_VALID && (O_MSG_KIND == K_ACT) |-> r.stage_ok && r.far_ok)
    else $error("activation without stored grid");
  activate_align_a: assert property ($changed(r.bank) |-> r.idx == 9'h0 && $past(I_CIF_COUNT[8:0]) == 9'h0
                                     && $past(r.armed))
    else $error("activation off alignment");
  index_wrap_a: assert property (I_CIF_TICK && (r.idx == `FGS_LAST_IDX) && !r.armed |=> r.idx == 9'h0)
    else $error("index did not wrap at 500");
  lsb_mask_a: assert property (!r.mode3 && $past(!r.mode3) && O_GRANT_VALID |-> !O_FIB_GRANT[0])
    else $error("fourth FIB granted outside mode three");
  abort_keeps_a: assert property (in_err && in_sess && (I_IN_CAUSE != `FGS_CAUSE_GRID)
                                  |=> (r.st == S_IDLE) && r.aborted && (r.far_ok == $past(r.far_ok)))
    else $error("abort did not end session");
  time_valid_a: assert property (time_ok(r.act_time))
    else $error("bad activation time held");
  bus_answer_a: assert property (bus_req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("bus answer late");

  // Message hold, upstream grid loss, busy refusal, held time, idle grant and close to idle
  msg_hold_a: assert property (O_MSG_VALID && !I_MSG_READY && !in_err
                               |=> O_MSG_VALID && $stable(O_MSG_KIND) && $stable(O_MSG_ALLOC))
    else $error("message dropped before accept");
  grid_loss_a: assert property (in_err && (I_IN_CAUSE == `FGS_CAUSE_GRID)
                                |=> !r.far_ok && !r.pend && !r.armed)
    else $error("grid loss upstream not honoured");
  busy_refused_a: assert property ((start_req || act_req) && (r.st != S_IDLE) |=> r.refused)
    else $error("busy request not flagged");
  time_locked_a: assert property (r.pend |=> $stable(r.act_time))
    else $error("activation time changed while pending");
  grant_idle_a: assert property (!O_GRANT_VALID |-> O_FIB_GRANT == 4'h0)
    else $error("grant shown before any activation");
  close_idle_a: assert property (send_acc && (O_MSG_KIND == K_CLOSE) |=> r.st == S_IDLE)
    else $error("session not closed after close");

  // Scenarios worth seeing
  session_done_c: cover property (send_acc && (O_MSG_KIND == K_CLOSE));
  refused_seen_c: cover property ($rose(r.refused));
  grid_swap_c: cover property ($changed(r.bank));
  error_sent_c: cover property (send_acc && (O_MSG_KIND == K_ERR));
  abort_seen_c: cover property ($rose(r.aborted));
endmodule
`default_nettype wire

// *** fgs_upstream_model.sv ***
// Upstream entity model: takes grid messages, sends requests and errors
`timescale 1ns/1ps
`default_nettype none
`include "fgs_consts.svh"
module fgs_upstream_model (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Messages from the device
  input  wire logic                msg_valid,
  input  wire fgs_pkg::fgs_kind_t  msg_kind,
  input  wire logic                slow,
  output logic                     msg_ready,
  // Bench commands
  input  wire logic                go,
  input  wire fgs_pkg::fgs_in_t    go_kind,
  input  wire logic [31:0]         go_cause,
  // Messages to the device
  output logic                     in_valid,
  output var fgs_pkg::fgs_in_t     in_kind,
  output logic [31:0]              in_cause
);
  import fgs_pkg::*;
  logic [1:0] pace;
  logic       open_r;
  logic       has_grid;
  // Slow mode takes one edge in four, as a busy far end would
  assign msg_ready = slow ? (pace == 2'h3) : 1'b1;
  // Session bookkeeping and outgoing messages
  always @(posedge clk)
  begin
    pace     <= pace + 2'h1;
    in_valid <= 1'b0;
    in_cause <= ~in_cause; // Idle cause never holds its last value
    if (rst)
    begin
      pace     <= 2'h0;
      open_r   <= 1'b0;
      has_grid <= 1'b0;
      in_kind  <= IN_REQ;
      in_cause <= 32'h00000000;
    end
    else if (go)
    begin
      in_valid <= 1'b1;
      in_kind  <= go_kind;
      in_cause <= go_cause;
    end
    else if (msg_valid && msg_ready && msg_kind == K_ACT && !has_grid)
    begin
      in_valid <= 1'b1;
      in_kind  <= IN_ERR;
      in_cause <= `FGS_CAUSE_GRID;
    end
    if (!rst && msg_valid && msg_ready)
    begin
      if (msg_kind == K_OPEN)
        open_r <= 1'b1;
      if (msg_kind == K_CLOSE)
        has_grid <= open_r;
    end
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the FIB grid scheduler
`timescale 1ns/1ps
`default_nettype none
`include "fgs_consts.svh"
module tb_top;
  import fgs_pkg::*;
  // ============================================================
  // Stimulus and observed signals
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, wq, mv, mr, go = 1'b0, slow = 1'b0;
  logic tick = 1'b0, tick_d = 1'b0, inv, gval;
  logic [11:0] ad = 12'h000;
  logic [31:0] wd = 32'h0, rdata, inc, goc = 32'h0, seed = 32'h00005155, r;
  logic [12:0] cnt = 13'h0000;
  logic [23:0] utc = 24'h000000;
  logic [3:0] grant;
  fgs_in_t ink, gok = IN_REQ;
  fgs_kind_t mk;
  logic [199:0] malloc, a;
  logic [63:0] mutc, rexp;
  logic [31:0] mcause;
  logic [203:0] mq[$];
  logic [63:0] rq[$];
  logic [4:0] gq[$];
  logic [3:0] grid[500];
  int bad_count = 0, comparisons = 0, n;
  always #20 clk = ~clk;
  fgs_scheduler DUT (.I_CLK_SYS(clk), .I_RESET(rst), .I_AVS_ADDRESS(ad), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(wq), .I_IN_VALID(inv), .I_IN_KIND(ink), .I_IN_CAUSE(inc), .O_MSG_VALID(mv),
    .I_MSG_READY(mr), .O_MSG_KIND(mk), .O_MSG_ALLOC(malloc), .O_MSG_UTC(mutc), .O_MSG_CAUSE(mcause),
    .I_CIF_TICK(tick), .I_CIF_COUNT(cnt), .I_UTC_BCD(utc), .O_FIB_GRANT(grant), .O_GRANT_VALID(gval));
  fgs_upstream_model U (.clk(clk), .rst(rst), .msg_valid(mv), .msg_kind(mk), .slow(slow),
    .msg_ready(mr), .go(go), .go_kind(gok), .go_cause(goc), .in_valid(inv), .in_kind(ink), .in_cause(inc));
  // ============================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [203:0] got, input logic [203:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Avalon master: hold the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [11:0] ad_i, input logic [31:0] d, input logic [31:0] m);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    ad <= ad_i;
    wd <= d;
    if (!w)
      rq.push_back({m, d & m});
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wq !== 1'b0 && n < 40);
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 40)
    begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic exp_msg(input fgs_kind_t k, input logic [199:0] d);
    mq.push_back({1'b0, k, d});
  endtask
  task automatic send(input fgs_in_t k, input logic [31:0] c);
    @(posedge clk);
    go  <= 1'b1;
    gok <= k;
    goc <= c;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic tick_at(input logic [12:0] c, input logic [4:0] e);
    @(posedge clk);
    tick <= 1'b1;
    cnt  <= c;
    gq.push_back(e);
    @(posedge clk);
    tick <= 1'b0;
  endtask
  // Bounded wait until every noted message has shown up
  task automatic wait_q();
    for (int t = 0; t < 5000 && mq.size() != 0; t++)
      @(posedge clk);
    if (mq.size() != 0)
    begin
      bad_count++;
      wrap_up();
    end
  endtask
  // ============================================================
  // Monitor: each result takes the oldest note off its queue
  always @(posedge clk)
  begin
    tick_d <= tick;
    if (rd && wq === 1'b0)
    begin
      rexp = rq.size() != 0 ? rq.pop_front() : '1;
      chk(204'(rdata & rexp[63:32]), 204'(rexp[31:0]));
    end
    if (mv && mr)
      chk({1'b0, mk, mk == K_REC ? malloc : mk == K_ACT ? 200'(mutc) : mk == K_ERR ? 200'(mcause) : 200'h0},
          mq.size() != 0 ? mq.pop_front() : '1);
    if (tick_d && gq.size() != 0)
      chk(204'({gval, grant}), 204'(gq.pop_front()));
  end
  // Watchdog against a hang
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
  // ============================================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, 12'h010, 32'hFFFFFFFF, 32'h0);
    for (int i = 0; i < 5; i++)
      bus(1'b0, 12'(i * 4), 32'h0, 32'hFFFFFFFF);
    for (int i = 0; i < 3; i++)
      bus(1'b1, 12'h008, i == 0 ? 32'h00240000 : i == 1 ? 32'h00006000 : 32'h00000060, 32'h0);
    bus(1'b0, 12'h008, 32'h0, 32'hFFFFFFFF);
    bus(1'b0, 12'h004, 32'h20, 32'h20);
    bus(1'b1, 12'h004, 32'h20, 32'h0);
    bus(1'b1, 12'h008, 32'h00235959, 32'h0);
    bus(1'b0, 12'h008, 32'h00235959, 32'hFFFFFFFF);
    // Load a random grid in mode III, first record all ones
    bus(1'b1, 12'h000, 32'h8, 32'h0);
    for (int i = 0; i < 500; i++)
    begin
      r = xs();
      grid[i] = i == 0 ? 4'hF : r[3:0];
      bus(1'b1, 12'h800 + 12'(i * 4), {28'h0, grid[i]}, 32'h0);
    end
    bus(1'b0, 12'hFCC, {28'h0, grid[499]}, 32'hF);
    bus(1'b1, 12'h000, 32'hC, 32'h0);
    // Full transfer session against a slow far end
    exp_msg(K_OPEN, 200'h0);
    for (int k = 0; k < 10; k++)
    begin
      for (int j = 0; j < 50; j++)
        a[199 - 4 * j -: 4] = grid[50 * k + j];
      exp_msg(K_REC, a);
    end
    exp_msg(K_CLOSE, 200'h0);
    slow <= 1'b1;
    send(IN_REQ, 32'h0);
    wait_q();
    bus(1'b0, 12'h004, 32'hA06, 32'hF06);
    // Timed activation, then a full grid cycle of ticks
    utc <= 24'h000002;
    bus(1'b1, 12'h008, 32'h00000001, 32'h0);
    exp_msg(K_ACT, 200'(64'h30303A30303A3031));
    bus(1'b1, 12'h000, 32'hE, 32'h0);
    wait_q();
    tick_at(13'h0005, 5'h00);
    tick_at(13'h0200, {1'b1, grid[0]});
    for (int i = 1; i <= 500; i++)
      tick_at(13'h0200 + 13'(i), {1'b1, grid[i % 500]});
    bus(1'b0, 12'h00C, 32'h0, 32'h1FF);
    // No grid left to offer or activate
    exp_msg(K_ERR, 200'(`FGS_CAUSE_GRID));
    send(IN_REQ, 32'h0);
    wait_q();
    bus(1'b1, 12'h000, 32'hA, 32'h0);
    bus(1'b0, 12'h004, 32'h20, 32'h20);
    // Session aborted by a content error
    slow <= 1'b0;
    // Mark the stage first: a start in the same write still sees it unmarked
    bus(1'b1, 12'h000, 32'hC, 32'h0);
    exp_msg(K_OPEN, 200'h0);
    bus(1'b1, 12'h000, 32'hD, 32'h0);
    wait_q();
    send(IN_ERR, `FGS_CAUSE_CNT);
    repeat (60) @(posedge clk);
    bus(1'b0, 12'h004, 32'h40, 32'h45);
    tick_at(13'h03F5, {1'b1, grid[1]});
    // Outside mode III the low record bit is dropped
    bus(1'b1, 12'h000, 32'h4, 32'h0);
    bus(1'b1, 12'h80C, 32'hF, 32'h0);
    bus(1'b0, 12'h80C, 32'hE, 32'hF);
    repeat (4) @(posedge clk);
    wrap_up();
  end
endmodule
`default_nettype wire
